// file: hw/gio_pkg.sv
// Shared constants and types for the general-purpose I/O logic
package gio_pkg;

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        GIO_UNUSED = 3'h0,
        GIO_INPUT  = 3'h1,
        GIO_OUTPUT = 3'h2,
        GIO_BIDIR  = 3'h3,
        GIO_CLKOUT = 3'h4
    } gio_mode_t;

    typedef enum logic [1:0] {
        GIO_DDR_OFF    = 2'h0,
        GIO_DDR_NORMAL = 2'h1,
        GIO_DDR_RESYNC = 2'h2,
        GIO_DDR_PIPE   = 2'h3
    } gio_ddr_t;

    // ------------------------------------------------------------------
    // Widths, counts and reset values
    // ------------------------------------------------------------------
    localparam int         GIO_SER_W     = 4;
    localparam logic [1:0] GIO_SER_LAST  = 2'h3;
    localparam logic [1:0] GIO_CNT_RST   = 2'h0;
    localparam logic [3:0] GIO_WORD_RST  = 4'h0;
    localparam logic       GIO_BIT_RST   = 1'b0;
    localparam logic [2:0] GIO_SYNC_RST  = 3'h0;

endpackage : gio_pkg

// file: hw/gio_out_if.sv
// Carrier between the pin logic and its output stage
`timescale 1ns/10ps
interface gio_out_if;
    import gio_pkg::*;
    gio_mode_t                mode;
    gio_ddr_t                 ddr;
    logic                     reg_en;
    logic                     neg_edge;
    logic                     invert;
    logic                     rise_d;
    logic                     fall_d;
    logic                     oe_d;
    logic                     ser_en;
    logic [GIO_SER_W-1:0]     ser_word;
    logic                     ser_ready;
    logic                     oe_eff;
    logic                     pad_o;
    logic                     pad_oe;

    modport pin  (output mode, ddr, reg_en, neg_edge, invert, rise_d,
                  fall_d, oe_d, ser_en, ser_word,
                  input  ser_ready, oe_eff, pad_o, pad_oe);
    modport path (input  mode, ddr, reg_en, neg_edge, invert, rise_d,
                  fall_d, oe_d, ser_en, ser_word,
                  output ser_ready, oe_eff, pad_o, pad_oe);
endinterface : gio_out_if

// file: hw/gio_out_path.sv
// Output and output-enable stage: registers, double-data mux, serializer
`timescale 1ns/10ps
module gio_out_path
    import gio_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link to the pin logic
    gio_out_if.path  o
);

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    logic                 pos_r;
    logic                 neg_r;
    logic                 oe_pos_r;
    logic                 oe_neg_r;
    logic                 rise_pipe_r;
    logic                 fall_hold_r;
    logic [1:0]           ser_cnt_r;
    logic [GIO_SER_W-1:0] ser_sh_r;
    wire                  is_ddr   = (o.ddr != GIO_DDR_OFF);
    wire                  rise_src = (o.ddr == GIO_DDR_PIPE) ? rise_pipe_r
                                                             : o.rise_d;
    // Retimed modes take the falling bit from a rising-edge stage first
    wire                  fall_src = (o.ddr == GIO_DDR_NORMAL) ? o.fall_d
                                                               : fall_hold_r;
    wire                  neg_src  = is_ddr ? fall_src : o.rise_d;
    wire                  launch   = o.neg_edge ? neg_r : pos_r;
    wire                  ddr_mux  = clk ? pos_r : neg_r;
    wire                  single_v = o.reg_en ? launch : o.rise_d;
    wire                  data_v   = o.ser_en ? ser_sh_r[0]
                                   : is_ddr   ? ddr_mux : single_v;
    wire                  oe_reg_v = o.neg_edge ? oe_neg_r : oe_pos_r;

    // ------------------------------------------------------------------
    // Rising-edge registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_r       <= GIO_BIT_RST;
            oe_pos_r    <= GIO_BIT_RST;
            rise_pipe_r <= GIO_BIT_RST;
            fall_hold_r <= GIO_BIT_RST;
        end else begin
            pos_r       <= rise_src;
            oe_pos_r    <= o.oe_d;
            rise_pipe_r <= o.rise_d;
            fall_hold_r <= o.fall_d;
        end
    end

    // ------------------------------------------------------------------
    // Falling-edge registers
    // ------------------------------------------------------------------
    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            neg_r    <= GIO_BIT_RST;
            oe_neg_r <= GIO_BIT_RST;
        end else begin
            neg_r    <= neg_src;
            oe_neg_r <= o.oe_d;
        end
    end

    // ------------------------------------------------------------------
    // Serializer, bit 0 leaves first
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ser_cnt_r <= GIO_CNT_RST;
            ser_sh_r  <= GIO_WORD_RST;
        end else if (ser_cnt_r == GIO_SER_LAST) begin
            ser_cnt_r <= GIO_CNT_RST;
            ser_sh_r  <= o.ser_word;
        end else begin
            ser_cnt_r <= ser_cnt_r + 2'h1;
            ser_sh_r  <= {1'b0, ser_sh_r[GIO_SER_W-1:1]};
        end
    end

    // ------------------------------------------------------------------
    // Pad drive
    // ------------------------------------------------------------------
    assign o.ser_ready = (ser_cnt_r == GIO_SER_LAST) & o.ser_en;
    assign o.oe_eff    = o.reg_en ? oe_reg_v : o.oe_d;
    // Clock out mode forwards the core clock itself, never a register
    assign o.pad_o     = (o.mode == GIO_CLKOUT) ? clk
                       : (data_v ^ o.invert);
    assign o.pad_oe    = (o.mode == GIO_CLKOUT) | (o.mode == GIO_OUTPUT)
                       | ((o.mode == GIO_BIDIR) & o.oe_eff);

endmodule : gio_out_path

// file: hw/gio_io_logic.sv
// General-purpose pin logic between core fabric and one pad
// Operation
// - Input, output and output-enable registers exist.
// - Input path combinational or registered, edge selectable.
// - Alternate input path has no capture flop.
// - Alternate input feeds another block directly.
// - Double-data input samples on both edges.
// - Output path combinational or registered, edge selectable.
// - Output value can be inverted.
// - Double-data output muxes two edge registers.
// - Bidirectional: input clock in, output clock out, OE.
// - Bidirectional edges and registering chosen independently; OE shares out_reg_en and out_neg_edge.
// - Clock output mode drives core clock to pad.
// - Weak pull-up on every pin during configuration.
// - Unused pins tristate, pull-up or optional pull-down.
// - Double-data core interface is two bits wide.
// - Normal double-data exchanges bits on both edges.
// - Resync and pipeline pass both bits on rising edge.
// - Resync delays falling bit by half a cycle.
// - Four-bit serdes only on high-speed pins.
// - First input bit rising, second falling sample.
// - First deserialized bit on lowest line.
`timescale 1ns/10ps
module gio_io_logic
    import gio_pkg::*;
#(
    parameter bit HIGH_SPEED = 1'b1
) (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Configuration
    input  wire logic                 configuring,
    input  wire gio_mode_t            mode,
    input  wire gio_ddr_t             ddr_mode,
    input  wire logic                 in_reg_en,
    input  wire logic                 in_neg_edge,
    input  wire logic                 out_reg_en,
    input  wire logic                 out_neg_edge,
    input  wire logic                 out_invert,
    input  wire logic                 pulldown_sel,
    input  wire logic                 alt_sel,
    input  wire logic                 serdes_en,
    // Core side, toward the pad
    input  wire logic                 rise_launch_out,
    input  wire logic                 fall_launch_out,
    input  wire logic                 oe_in,
    input  wire logic [GIO_SER_W-1:0] ser_word_out,
    output wire logic                 ser_ready,
    // Core side, from the pad
    output wire logic                 rise_sample_in,
    output wire logic                 fall_sample_in,
    output wire logic [GIO_SER_W-1:0] deser_data,
    output wire logic                 deser_valid,
    // Alternate function
    output wire logic                 alt_out,
    // Pad
    input  wire logic                 pad_i,
    output wire logic                 pad_o,
    output wire logic                 pad_oe,
    output wire logic                 pull_up_en,
    output wire logic                 pull_down_en
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire in_active  = (mode == GIO_INPUT) | (mode == GIO_BIDIR);
    wire out_active = (mode == GIO_OUTPUT) | (mode == GIO_BIDIR)
                    | (mode == GIO_CLKOUT);
    wire is_ddr     = (ddr_mode != GIO_DDR_OFF);
    wire ser_on     = serdes_en & HIGH_SPEED;
    // Alternate use leaves the rise and fall samples to the core idle
    wire core_in_on = in_active & ~alt_sel;

    // ------------------------------------------------------------------
    // Pad synchronizer
    // ------------------------------------------------------------------
    logic [2:0] sync_r;
    logic       pad_q_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_r <= GIO_SYNC_RST;
        end else begin
            sync_r <= {sync_r[1:0], pad_i};
        end
    end

    // Accept a change only once stages two and three agree
    wire sync_agree = (sync_r[1] == sync_r[2]);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_q_r <= GIO_BIT_RST;
        end else if (sync_agree) begin
            pad_q_r <= sync_r[2];
        end
    end

    // ------------------------------------------------------------------
    // Input capture registers
    // ------------------------------------------------------------------
    logic pos_cap_r;
    logic neg_cap_r;
    logic fall_rs_r;
    logic rise_pp_r;
    logic fall_pp_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pos_cap_r <= GIO_BIT_RST;
        end else begin
            pos_cap_r <= pad_q_r;
        end
    end

    always_ff @(negedge clk or posedge rst) begin
        if (rst) begin
            neg_cap_r <= GIO_BIT_RST;
        end else begin
            neg_cap_r <= pad_q_r;
        end
    end

    // Half-cycle hold moves the falling sample onto the rising edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fall_rs_r <= GIO_BIT_RST;
            rise_pp_r <= GIO_BIT_RST;
            fall_pp_r <= GIO_BIT_RST;
        end else begin
            fall_rs_r <= neg_cap_r;
            rise_pp_r <= pos_cap_r;
            fall_pp_r <= fall_rs_r;
        end
    end

    // ------------------------------------------------------------------
    // Input selection toward the core
    // ------------------------------------------------------------------
    wire single_cap = in_neg_edge ? neg_cap_r : pos_cap_r;
    wire single_in  = in_reg_en ? single_cap : pad_q_r;
    wire rise_ddr   = (ddr_mode == GIO_DDR_PIPE) ? rise_pp_r
                                                 : pos_cap_r;
    wire fall_ddr   = (ddr_mode == GIO_DDR_NORMAL) ? neg_cap_r
                    : (ddr_mode == GIO_DDR_RESYNC) ? fall_rs_r
                    : fall_pp_r;

    assign rise_sample_in = core_in_on & (is_ddr ? rise_ddr : single_in);
    assign fall_sample_in = core_in_on & is_ddr & fall_ddr;

    // The raw pin goes straight out; no flop may add latency here
    assign alt_out = alt_sel & pad_i;

    // ------------------------------------------------------------------
    // Deserializer, first bit lands on line 0
    // ------------------------------------------------------------------
    logic [1:0]           des_cnt_r;
    logic [GIO_SER_W-1:0] des_sh_r;
    logic [GIO_SER_W-1:0] des_word_r;
    logic                 des_vld_r;
    wire  [GIO_SER_W-1:0] des_next = {pad_q_r, des_sh_r[GIO_SER_W-1:1]};
    wire                  des_last = (des_cnt_r == GIO_SER_LAST);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            des_cnt_r  <= GIO_CNT_RST;
            des_sh_r   <= GIO_WORD_RST;
            des_word_r <= GIO_WORD_RST;
            des_vld_r  <= GIO_BIT_RST;
        end else begin
            des_cnt_r <= ser_on ? des_cnt_r + 2'h1 : GIO_CNT_RST;
            des_sh_r  <= des_next;
            des_vld_r <= ser_on & des_last;
            if (ser_on & des_last) begin
                des_word_r <= des_next;
            end
        end
    end

    assign deser_data  = des_word_r;
    assign deser_valid = des_vld_r;

    // ------------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------------
    gio_out_if ob ();

    assign ob.mode     = mode;
    assign ob.ddr      = ddr_mode;
    assign ob.reg_en   = out_reg_en;
    assign ob.neg_edge = out_neg_edge;
    assign ob.invert   = out_invert;
    assign ob.rise_d   = rise_launch_out;
    assign ob.fall_d   = fall_launch_out;
    assign ob.oe_d     = oe_in;
    assign ob.ser_en   = ser_on;
    assign ob.ser_word = ser_word_out;

    gio_out_path u_out (
        .clk (clk),
        .rst (rst),
        .o   (ob.path)
    );

    // ------------------------------------------------------------------
    // Pad control and pulls
    // ------------------------------------------------------------------
    wire idle_pin = ~(in_active | out_active);

    // Configuration overrides the output enable and the pulls, so the pin never drives early
    assign pad_o        = ob.pad_o;
    assign pad_oe       = ~configuring & ob.pad_oe;
    assign pull_up_en   = configuring
                        | (idle_pin & ~pulldown_sel);
    assign pull_down_en = ~configuring & idle_pin & pulldown_sel;
    assign ser_ready    = ob.ser_ready;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_pad_steady;
        pad_i [*3];
    endsequence

    property p_sync_pass;
        @(posedge clk) disable iff (rst)
        s_pad_steady |-> ##2 pad_q_r;
    endproperty
    a_sync_pass: assert property (p_sync_pass)
        else $error("pad level not accepted after stable input");

    property p_in_reg;
        @(posedge clk) disable iff (rst)
        (mode == GIO_INPUT && !alt_sel && !is_ddr && in_reg_en
         && !in_neg_edge) |-> rise_sample_in == $past(pad_q_r);
    endproperty
    a_in_reg: assert property (p_in_reg)
        else $error("registered input does not follow pad");

    property p_alt_bypass;
        @(posedge clk) disable iff (rst)
        alt_sel |-> (alt_out == pad_i) && !rise_sample_in;
    endproperty
    a_alt_bypass: assert property (p_alt_bypass)
        else $error("alternate path registered or core not idle");

    property p_resync;
        @(posedge clk) disable iff (rst)
        (in_active && !alt_sel && ddr_mode == GIO_DDR_RESYNC)
        |-> fall_sample_in == $past(neg_cap_r);
    endproperty
    a_resync: assert property (p_resync)
        else $error("resync falling bit misaligned");

    sequence s_pipe_held;
        (ddr_mode == GIO_DDR_PIPE && in_active && !alt_sel) [*2];
    endsequence

    property p_pipe;
        @(posedge clk) disable iff (rst)
        s_pipe_held |-> rise_sample_in == $past(pad_q_r, 2);
    endproperty
    a_pipe: assert property (p_pipe)
        else $error("pipeline rising bit wrong latency");

    property p_config_pull;
        @(posedge clk) disable iff (rst)
        configuring |-> pull_up_en && !pull_down_en && !pad_oe;
    endproperty
    a_config_pull: assert property (p_config_pull)
        else $error("pin not weakly pulled up while configuring");

    property p_unused;
        @(posedge clk) disable iff (rst)
        (!configuring && mode == GIO_UNUSED)
        |-> !pad_oe && (pull_up_en != pull_down_en)
            && (pull_down_en == pulldown_sel);
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused pin pull selection wrong");

    property p_oe_gate;
        @(posedge clk) disable iff (rst)
        (mode == GIO_BIDIR && !configuring && !out_neg_edge)
        |-> pad_oe == (out_reg_en ? $past(oe_in) : oe_in);
    endproperty
    a_oe_gate: assert property (p_oe_gate)
        else $error("bidirectional drive does not follow enable");

    property p_invert;
        @(posedge clk) disable iff (rst)
        (mode == GIO_OUTPUT && !is_ddr && !out_reg_en && !ser_on)
        |-> pad_o == (rise_launch_out ^ out_invert);
    endproperty
    a_invert: assert property (p_invert)
        else $error("output inversion wrong");

    property p_deser;
        @(posedge clk) disable iff (rst)
        deser_valid |-> deser_data[0] == $past(pad_q_r, 4)
                     && deser_data[3] == $past(pad_q_r, 1);
    endproperty
    a_deser: assert property (p_deser)
        else $error("deserializer bit order wrong");

    property p_serdes_pin;
        @(posedge clk) disable iff (rst)
        !HIGH_SPEED |-> !deser_valid && !ser_ready;
    endproperty
    a_serdes_pin: assert property (p_serdes_pin)
        else $error("serdes active on a non high-speed pin");

endmodule : gio_io_logic

// file: test/gio_pad_model.sv
// Pad wire and far-side driver model for the pin logic bench
`timescale 1ns/10ps
module gio_pad_model (
    // Clock
    input  wire logic clk,
    // Pad as seen by the pin logic
    input  wire logic pad_o,
    input  wire logic pad_oe,
    input  wire logic pull_up_en,
    input  wire logic pull_down_en,
    output wire logic pad_i,
    // External driver on the board
    input  wire logic ext_en,
    input  wire logic ext_val
);
    logic float_r = 1'b0;

    // A floating pad wanders, so a stale level never passes for a real one
    always @(posedge clk) begin
        float_r <= ~float_r;
    end

    // Pad delay keeps the level off the clock edge that launched it
    assign #1 pad_i = pad_oe  ? pad_o   :
                   ext_en     ? ext_val :
                   pull_up_en ? 1'b1    :
                   pull_down_en ? 1'b0  : float_r;
endmodule : gio_pad_model

// file: test/gio_io_logic_tb.sv
// Self-checking bench for the general-purpose pin logic
`timescale 1ns/10ps
module gio_io_logic_tb;
    import gio_pkg::*;

    logic       clk = 1'b0, rst = 1'b1, configuring = 1'b0;
    gio_mode_t  mode = GIO_UNUSED;
    gio_ddr_t   ddr_mode = GIO_DDR_OFF;
    logic       in_reg_en = 1'b0, in_neg_edge = 1'b0, out_reg_en = 1'b0;
    logic       out_neg_edge = 1'b0, out_invert = 1'b0, pulldown_sel = 1'b0;
    logic       alt_sel = 1'b0, serdes_en = 1'b0, oe_in = 1'b0;
    logic       rise_launch_out = 1'b0, fall_launch_out = 1'b0;
    logic [3:0] ser_word_out = 4'h0;
    logic       ext_en = 1'b0, ext_val = 1'b0;
    wire        ser_ready, rise_sample_in, fall_sample_in, deser_valid;
    wire  [3:0] deser_data;
    wire        alt_out, pad_i, pad_o, pad_oe, pull_up_en, pull_down_en;
    int         err_count = 0, check_count = 0;

    always #5 clk = ~clk;

    gio_io_logic DUT (.clk(clk), .rst(rst), .configuring(configuring),
        .mode(mode), .ddr_mode(ddr_mode), .in_reg_en(in_reg_en),
        .in_neg_edge(in_neg_edge), .out_reg_en(out_reg_en),
        .out_neg_edge(out_neg_edge), .out_invert(out_invert),
        .pulldown_sel(pulldown_sel), .alt_sel(alt_sel),
        .serdes_en(serdes_en), .rise_launch_out(rise_launch_out),
        .fall_launch_out(fall_launch_out), .oe_in(oe_in),
        .ser_word_out(ser_word_out), .ser_ready(ser_ready),
        .rise_sample_in(rise_sample_in), .fall_sample_in(fall_sample_in),
        .deser_data(deser_data), .deser_valid(deser_valid),
        .alt_out(alt_out), .pad_i(pad_i), .pad_o(pad_o), .pad_oe(pad_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

    gio_pad_model pad (.clk(clk), .pad_o(pad_o), .pad_oe(pad_oe),
        .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
        .pad_i(pad_i), .ext_en(ext_en), .ext_val(ext_val));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic step(int n);
        repeat (n) @(posedge clk);
    endtask : step

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_pulls();
        @(posedge clk);
        configuring <= 1'b1;
        #2 check("pull_up_en", pull_up_en, 1);
        check("pad_oe", pad_oe, 0);
        @(posedge clk);
        configuring <= 1'b0;
        #2 check("pull_up_en", pull_up_en, 1);
        check("pad_oe", pad_oe, 0);
        @(posedge clk);
        pulldown_sel <= 1'b1;
        #2 check("pull_up_en", pull_up_en, 0);
        check("pull_down_en", pull_down_en, 1);
    endtask : t_pulls

    task automatic t_out();
        @(posedge clk);
        mode <= GIO_OUTPUT;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            rise_launch_out <= i[0];
            out_invert <= i[1];
            #2 check("pad_o comb", pad_o, i[0] ^ i[1]);
            check("pad_oe", pad_oe, 1);
        end
        @(posedge clk);
        out_invert <= 1'b0;
        out_reg_en <= 1'b1;
        rise_launch_out <= 1'b0;
        step(2);
        rise_launch_out <= 1'b1;
        #2 check("pad_o held", pad_o, 0);
        @(posedge clk);
        out_neg_edge <= 1'b1;
        rise_launch_out <= 1'b0;
        #2 check("pad_o launched", pad_o, 1);
        @(negedge clk);
        #2 check("pad_o fall launch", pad_o, 0);
        @(posedge clk);
        out_neg_edge <= 1'b0;
    endtask : t_out

    task automatic t_bidir();
        @(posedge clk);
        mode <= GIO_BIDIR;
        out_reg_en <= 1'b0;
        rise_launch_out <= 1'b1;
        #2 check("pad_oe off", pad_oe, 0);
        @(posedge clk);
        oe_in <= 1'b1;
        #2 check("pad_oe on", pad_oe, 1);
        check("pad_o", pad_o, 1);
        @(posedge clk);
        out_reg_en <= 1'b1;
        oe_in <= 1'b0;
        ext_en <= 1'b1;
        ext_val <= 1'b1;
        #2 check("pad_oe held", pad_oe, 1);
        step(1);
        #2 check("pad_oe reg", pad_oe, 0);
        step(6);
        #2 check("bidir comb in", rise_sample_in, 1);
    endtask : t_bidir

    task automatic t_in();
        @(posedge clk);
        mode <= GIO_INPUT;
        in_reg_en <= 1'b1;
        step(7);
        #2 check("pad_oe", pad_oe, 0);
        check("rise_sample_in", rise_sample_in, 1);
        check("fall_sample_in", fall_sample_in, 0);
        @(posedge clk);
        ext_val <= 1'b0;
        in_neg_edge <= 1'b1;
        step(6);
        #2 check("neg edge in", rise_sample_in, 0);
        @(posedge clk);
        in_neg_edge <= 1'b0;
        ext_val <= 1'b1;
        @(posedge clk);
        ext_val <= 1'b0;
        // A one-cycle glitch must never reach the core
        repeat (6) begin
            @(posedge clk);
            #2 check("glitch", rise_sample_in, 0);
        end
        // Normal, resync and pipeline input, level flipped for each
        for (int k = 1; k < 4; k++) begin
            @(posedge clk);
            ddr_mode <= gio_ddr_t'(k);
            ext_val <= k[0];
            step(8);
            #2 check("ddr rise", rise_sample_in, k[0]);
            check("ddr fall", fall_sample_in, k[0]);
        end
        @(posedge clk);
        ddr_mode <= GIO_DDR_OFF;
        alt_sel <= 1'b1;
        ext_val <= 1'b0;
        #2 check("alt_out", alt_out, 0);
        @(posedge clk);
        ext_val <= 1'b1;
        #2 check("alt_out", alt_out, 1);
        step(6);
        #2 check("alt core in", rise_sample_in, 0);
        @(posedge clk);
        alt_sel <= 1'b0;
        ext_en <= 1'b0;
    endtask : t_in

    task automatic t_clkout();
        @(posedge clk);
        mode <= GIO_CLKOUT;
        step(1);
        #2 check("clk out high", pad_o, 1);
        check("clk out oe", pad_oe, 1);
        @(negedge clk);
        #2 check("clk out low", pad_o, 0);
    endtask : t_clkout

    task automatic t_ddr_out();
        gio_ddr_t   m [3] = '{GIO_DDR_NORMAL, GIO_DDR_RESYNC, GIO_DDR_PIPE};
        logic [5:0] e [3] = '{6'h1f, 6'h0f, 6'h07};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk);
            mode <= GIO_OUTPUT;
            ddr_mode <= m[k];
            rise_launch_out <= 1'b0;
            fall_launch_out <= 1'b0;
            step(3);
            rise_launch_out <= 1'b1;
            fall_launch_out <= 1'b1;
            for (int j = 5; j > 0; j -= 2) begin
                #2 check("ddr high", pad_o, e[k][j]);
                @(negedge clk);
                #2 check("ddr low", pad_o, e[k][j-1]);
                @(posedge clk);
            end
        end
        ddr_mode <= GIO_DDR_OFF;
    endtask : t_ddr_out

    task automatic t_serdes();
        @(posedge clk);
        serdes_en <= 1'b1;
        ser_word_out <= 4'h3;
        repeat (8) begin
            @(posedge clk);
            #2;
            if (ser_ready === 1'b1)
                break;
        end
        check("ser_ready", ser_ready, 1);
        // Word changes after loading, so a late load shows up as zeros
        for (int b = 0; b < 4; b++) begin
            @(posedge clk);
            ser_word_out <= 4'h0;
            #2 check("ser bit", pad_o, b < 2);
            check("ser_ready", ser_ready, b == 3);
        end
        @(posedge clk);
        mode <= GIO_INPUT;
        ext_en <= 1'b1;
        ext_val <= 1'b0;
        step(8);
        repeat (8) begin
            @(posedge clk);
            #2;
            if (deser_valid === 1'b1)
                break;
        end
        // Rise late enough that only the last two bits of a word are high
        step(2);
        ext_val <= 1'b1;
        step(6);
        #2 check("deser_valid", deser_valid, 1);
        check("deser_data", deser_data, 4'hc);
    endtask : t_serdes

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        #12 check("reset sample", rise_sample_in, 0);
        check("reset valid", deser_valid, 0);
        step(3);
        rst <= 1'b0;
        t_pulls();
        t_out();
        t_bidir();
        t_in();
        t_clkout();
        t_ddr_out();
        t_serdes();
        complete_run();
    end

    initial begin
        #20000;
        err_count++;
        complete_run();
    end
endmodule : gio_io_logic_tb
